// [shared/sdds_consts.vh]
`ifndef SDDS_CONSTS_VH
`define SDDS_CONSTS_VH

// Register bus geometry
`define SDDS_AW 5
`define SDDS_DW 10

// Configuration register indices (word addresses on the plain port)
`define SDDS_R_CTRL 5'h00
`define SDDS_R_SLAM_THR 5'h01
`define SDDS_R_SLAM_RATE 5'h02
`define SDDS_R_WIPER_ACC 5'h03
`define SDDS_R_LOW_FWD 5'h04
`define SDDS_R_LOW_REV 5'h05
`define SDDS_R_MAX_REV 5'h06
`define SDDS_R_LIM_FWD 5'h07
`define SDDS_R_LIM_ACC 5'h08
`define SDDS_R_LIM_DEC 5'h09
`define SDDS_R_P1_MAXF 5'h0A
`define SDDS_R_P1_ACC 5'h0B
`define SDDS_R_P1_DEC 5'h0C
`define SDDS_R_P2_MAXF 5'h0D
`define SDDS_R_P2_ACC 5'h0E
`define SDDS_R_P2_DEC 5'h0F
`define SDDS_R_THR_MIN 5'h10
`define SDDS_R_THR_MAX 5'h11
`define SDDS_R_NEUTRAL 5'h12
`define SDDS_N_CFG 19
`define SDDS_R_STATUS 5'h13
`define SDDS_R_SPEED 5'h14

// Control register bits
`define SDDS_C_NONLATCH 0
`define SDDS_C_POT_EN 1
`define SDDS_C_SLAM_EN 2
`define SDDS_C_WIPER_EN 3
`define SDDS_C_WIGWAG 4
`define SDDS_C_PROF_PIN 5
`define SDDS_C_THR_TEST 6

// Status register bits
`define SDDS_S_THR_FAULT 0
`define SDDS_S_WIPER_FAULT 1
`define SDDS_S_SLAM 2
`define SDDS_S_PROFILE2 3

// Reset values
`define SDDS_RV_CTRL 10'h042
`define SDDS_RV_SLAM_THR 10'h000
`define SDDS_RV_SLAM_RATE 10'h064
`define SDDS_RV_WIPER_ACC 10'h000
`define SDDS_RV_LOW_FWD 10'h014
`define SDDS_RV_LOW_REV 10'h00A
`define SDDS_RV_MAX_REV 10'h028
`define SDDS_RV_LIM 10'h064
`define SDDS_RV_MAXF 10'h03C
`define SDDS_RV_ACC 10'h028
`define SDDS_RV_DEC 10'h03C
`define SDDS_RV_THR_MIN 10'h021
`define SDDS_RV_THR_MAX 10'h3E2
`define SDDS_RV_NEUTRAL 10'h200

// Value ranges
`define SDDS_PCT_MAX 10'h064
`define SDDS_MAXF_MIN 10'h014
`define SDDS_ACC_MAX 10'h00F

// Scale: full scale speed and window margin (10 % of full scale)
`define SDDS_FS 10'h3FF
`define SDDS_MARGIN 11'h066
// Divide by 100 as multiply by 1311 then shift 17
`define SDDS_DIV100_K 11'h51F
`define SDDS_DIV100_SH 17
`define SDDS_POT_SH 10

// Timing
`define SDDS_CLK_HZ 25000000
`define SDDS_RAMP_SLOW_MS 10000
`define SDDS_RAMP_FAST_MS 400
`define SDDS_RAMP_PCT_STEP ((`SDDS_RAMP_SLOW_MS - `SDDS_RAMP_FAST_MS) / 100)
`define SDDS_WIPER_STEP_MS 20

`endif

// [src/sdds_ramp.v]
`default_nettype none
`include "sdds_consts.vh"

module sdds_ramp #(
   parameter CYC_PER_MS = `SDDS_CLK_HZ / 1000
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire clr,
   input wire signed [10:0] target,
   input wire [6:0] rate_pct,
   output reg signed [10:0] cur_q
);

   localparam [31:0] CPM = CYC_PER_MS;

   reg [31:0] phase_q;
   wire [31:0] ramp_ms;
   wire [31:0] ramp_cyc;
   wire [31:0] phase_inc;

   // Full-scale ramp time falls linearly with the setting, so it is monotonic
   assign ramp_ms = `SDDS_RAMP_SLOW_MS - `SDDS_RAMP_PCT_STEP * {25'h0000000, rate_pct};
   assign ramp_cyc = ramp_ms * CPM;
   assign phase_inc = phase_q + {22'h000000, `SDDS_FS};

   // Bresenham stepping: full scale is covered in exactly ramp_cyc clocks
   always @(posedge clk) begin
      if (rst) begin
         phase_q <= 32'h00000000;
         cur_q <= 11'h000;
      end else if (ce) begin
         if (clr) begin
            phase_q <= 32'h00000000;
            cur_q <= 11'h000;
         end else if (cur_q == target) begin
            phase_q <= 32'h00000000;
         end else if (phase_inc >= ramp_cyc) begin
            phase_q <= phase_inc - ramp_cyc;
            if (cur_q < target) begin
               cur_q <= cur_q + 11'sh001;
            end else begin
               cur_q <= cur_q - 11'sh001;
            end
         end else begin
            phase_q <= phase_inc;
         end
      end
   end

endmodule // sdds_ramp

`default_nettype wire

// [src/sdds_shaper.v]
// Function
// - Fault latching setting, default latched
// - Non-latching fault clear resumes throttle demand immediately
// - Speed pot limits speed only when enabled
// - Pot high gives maximum, low gives lowest
// - Pot scales demand proportionally, never clips
// - Unconnected pot reads lowest setting
// - Slam enable covers both directions, default off
// - Slam starts on opposite throttle beyond threshold
// - Slam uses slam rate, not deceleration
// - Broken wiper test only for wig-wag
// - Accuracy adds 20 ms detection each step
// - Break reads neutral; flag only once stopped
// - Profile two only with pin configured, active
// - Maximum forward speed 20-100, default 60
// - Refuse settings above manufacturer limits
// - Acceleration ramp 10 s to 0.4 s
// - Deceleration ramp 10 s to 0.4 s
// - Lowest forward speed caps at pot minimum
// - Wiper beyond window by 10 % faults
`default_nettype none
`include "sdds_consts.vh"

module sdds_shaper #(
   parameter CYC_PER_MS = `SDDS_CLK_HZ / 1000
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [`SDDS_AW-1:0] reg_addr,
   input wire [`SDDS_DW-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`SDDS_DW-1:0] reg_rdata_q,
   input wire [9:0] throttle_adc,
   input wire [9:0] pot_adc,
   input wire profile_pin,
   input wire wiper_open_pin,
   output reg signed [10:0] speed_demand_q,
   output reg drive_inhibit_q,
   output reg throttle_fault_q,
   output reg wiper_fault_q,
   output reg slam_active_q,
   output reg profile2_q
);

   localparam [31:0] CPM = CYC_PER_MS;
   localparam [15:0] WIPER_STEP_MS = `SDDS_WIPER_STEP_MS;

   // Reset value of each configuration word
   function [9:0] f_rstval;
      input [4:0] idx;
      begin
         case (idx)
            `SDDS_R_CTRL: f_rstval = `SDDS_RV_CTRL;
            `SDDS_R_SLAM_THR: f_rstval = `SDDS_RV_SLAM_THR;
            `SDDS_R_SLAM_RATE: f_rstval = `SDDS_RV_SLAM_RATE;
            `SDDS_R_WIPER_ACC: f_rstval = `SDDS_RV_WIPER_ACC;
            `SDDS_R_LOW_FWD: f_rstval = `SDDS_RV_LOW_FWD;
            `SDDS_R_LOW_REV: f_rstval = `SDDS_RV_LOW_REV;
            `SDDS_R_MAX_REV: f_rstval = `SDDS_RV_MAX_REV;
            `SDDS_R_LIM_FWD: f_rstval = `SDDS_RV_LIM;
            `SDDS_R_LIM_ACC: f_rstval = `SDDS_RV_LIM;
            `SDDS_R_LIM_DEC: f_rstval = `SDDS_RV_LIM;
            `SDDS_R_P1_MAXF: f_rstval = `SDDS_RV_MAXF;
            `SDDS_R_P1_ACC: f_rstval = `SDDS_RV_ACC;
            `SDDS_R_P1_DEC: f_rstval = `SDDS_RV_DEC;
            `SDDS_R_P2_MAXF: f_rstval = `SDDS_RV_MAXF;
            `SDDS_R_P2_ACC: f_rstval = `SDDS_RV_ACC;
            `SDDS_R_P2_DEC: f_rstval = `SDDS_RV_DEC;
            `SDDS_R_THR_MIN: f_rstval = `SDDS_RV_THR_MIN;
            `SDDS_R_THR_MAX: f_rstval = `SDDS_RV_THR_MAX;
            `SDDS_R_NEUTRAL: f_rstval = `SDDS_RV_NEUTRAL;
            default: f_rstval = 10'h000;
         endcase
      end
   endfunction

   // Percentage scaling: mag * pct / 100, proportional so no dead band appears
   function [9:0] f_scale;
      input [9:0] mag;
      input [9:0] pct;
      reg [37:0] prod;
      begin
         prod = {28'h0000000, mag} * {28'h0000000, pct} * {27'h0000000, `SDDS_DIV100_K};
         f_scale = prod[`SDDS_DIV100_SH+9:`SDDS_DIV100_SH];
      end
   endfunction

   // Magnitude of a signed speed value
   function [9:0] f_abs;
      input signed [10:0] v;
      reg [10:0] n;
      begin
         n = -v;
         f_abs = v[10] ? n[9:0] : v[9:0];
      end
   endfunction

   // Top speed between lowest and maximum as the pot moves from low to high
   function [9:0] f_top;
      input [9:0] lowest;
      input [9:0] highest;
      input [9:0] pot;
      input pot_en;
      reg [19:0] span;
      reg [19:0] quot;
      begin
         if (!pot_en) begin
            f_top = highest;
         end else if (highest <= lowest) begin
            f_top = lowest;
         end else begin
            // Divide by full scale so a pot at the top rail gives exactly the maximum
            span = {10'h000, highest - lowest} * {10'h000, pot};
            quot = span / {10'h000, `SDDS_FS};
            f_top = lowest + quot[9:0];
         end
      end
   endfunction

   reg [9:0] cfg_q [0:`SDDS_N_CFG-1];
   reg prof_s1_q, prof_s2_q, prof_s3_q, prof_q;
   reg wip_s1_q, wip_s2_q, wip_s3_q, wip_q;
   reg [31:0] ms_cnt_q;
   reg [15:0] wip_ms_q;
   reg slam_q;
   integer i;

   wire [9:0] ctrl = cfg_q[`SDDS_R_CTRL];
   wire [9:0] lim_fwd = cfg_q[`SDDS_R_LIM_FWD];
   wire [9:0] lim_acc = cfg_q[`SDDS_R_LIM_ACC];
   wire [9:0] lim_dec = cfg_q[`SDDS_R_LIM_DEC];
   wire wr_ok;
   wire w1c_wiper;
   wire ms_tick;
   wire wiper_broken;
   wire thr_cause;
   wire thr_fault_d;
   wire [9:0] max_fwd, acc_pct, dec_pct;
   wire [9:0] top_fwd, top_rev;
   wire signed [11:0] dev;
   wire signed [10:0] thr_pos;
   wire [9:0] thr_mag;
   wire signed [10:0] target;
   wire signed [10:0] ramp_cur;
   wire opposite;
   wire slam_d;
   wire accel;
   wire [9:0] rate_sel;
   wire [9:0] rate_lim;
   wire [6:0] rate_pct;
   wire stopped;
   wire [15:0] wip_need_ms;

   // Write acceptance: out-of-range or above-limit values are refused outright
   assign wr_ok = (reg_addr == `SDDS_R_P1_MAXF || reg_addr == `SDDS_R_P2_MAXF) ?
                  (reg_wdata >= `SDDS_MAXF_MIN && reg_wdata <= lim_fwd) :
                  (reg_addr == `SDDS_R_P1_ACC || reg_addr == `SDDS_R_P2_ACC) ?
                  (reg_wdata <= lim_acc) :
                  (reg_addr == `SDDS_R_P1_DEC || reg_addr == `SDDS_R_P2_DEC) ?
                  (reg_wdata <= lim_dec) :
                  (reg_addr == `SDDS_R_WIPER_ACC) ? (reg_wdata <= `SDDS_ACC_MAX) :
                  (reg_addr == `SDDS_R_CTRL || reg_addr >= `SDDS_R_THR_MIN) ? 1'b1 :
                  (reg_wdata <= `SDDS_PCT_MAX);
   assign w1c_wiper = reg_wr && reg_addr == `SDDS_R_STATUS && reg_wdata[`SDDS_S_WIPER_FAULT];

   // Configuration store
   always @(posedge clk) begin
      if (rst) begin
         for (i = 0; i < `SDDS_N_CFG; i = i + 1) begin
            cfg_q[i] <= f_rstval(i[4:0]);
         end
      end else if (ce) begin
         if (reg_wr && reg_addr < `SDDS_N_CFG && wr_ok) begin
            cfg_q[reg_addr] <= reg_wdata;
         end
      end
   end

   // Read data one cycle after the strobe; unmapped words read zero
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata_q <= 10'h000;
      end else if (ce) begin
         if (!reg_rd) begin
            reg_rdata_q <= 10'h000;
         end else if (reg_addr < `SDDS_N_CFG) begin
            reg_rdata_q <= cfg_q[reg_addr];
         end else if (reg_addr == `SDDS_R_STATUS) begin
            reg_rdata_q <= {6'h00, profile2_q, slam_q, wiper_fault_q, throttle_fault_q};
         end else if (reg_addr == `SDDS_R_SPEED) begin
            reg_rdata_q <= ramp_cur[9:0];
         end else begin
            reg_rdata_q <= 10'h000;
         end
      end
   end

   // Pin synchronisers: a level counts once the second and third stages agree
   always @(posedge clk) begin
      if (rst) begin
         prof_s1_q <= 1'b0;
         prof_s2_q <= 1'b0;
         prof_s3_q <= 1'b0;
         prof_q <= 1'b0;
         wip_s1_q <= 1'b0;
         wip_s2_q <= 1'b0;
         wip_s3_q <= 1'b0;
         wip_q <= 1'b0;
      end else if (ce) begin
         prof_s1_q <= profile_pin;
         prof_s2_q <= prof_s1_q;
         prof_s3_q <= prof_s2_q;
         if (prof_s2_q == prof_s3_q) begin
            prof_q <= prof_s3_q;
         end
         wip_s1_q <= wiper_open_pin;
         wip_s2_q <= wip_s1_q;
         wip_s3_q <= wip_s2_q;
         if (wip_s2_q == wip_s3_q) begin
            wip_q <= wip_s3_q;
         end
      end
   end

   // Profile two needs both the pin function and an active pin
   assign max_fwd = profile2_q ? cfg_q[`SDDS_R_P2_MAXF] : cfg_q[`SDDS_R_P1_MAXF];
   assign acc_pct = profile2_q ? cfg_q[`SDDS_R_P2_ACC] : cfg_q[`SDDS_R_P1_ACC];
   assign dec_pct = profile2_q ? cfg_q[`SDDS_R_P2_DEC] : cfg_q[`SDDS_R_P1_DEC];

   // Throttle window test; a reading more than 10 % outside min..max is a fault
   assign thr_cause = ctrl[`SDDS_C_THR_TEST] &&
      (({1'b0, throttle_adc} + `SDDS_MARGIN < {1'b0, cfg_q[`SDDS_R_THR_MIN]}) ||
       ({1'b0, throttle_adc} > {1'b0, cfg_q[`SDDS_R_THR_MAX]} + `SDDS_MARGIN));
   // Latched unless non-latching is chosen; a new cause always wins
   assign thr_fault_d = thr_cause ||
                        (throttle_fault_q && !ctrl[`SDDS_C_NONLATCH]);

   // Broken wiper is only meaningful for wig-wag throttles; it reads as neutral
   assign wiper_broken = ctrl[`SDDS_C_WIGWAG] && wip_q;

   // Throttle deflection about neutral, doubled to full scale and clipped
   assign dev = {2'b00, throttle_adc} - {2'b00, cfg_q[`SDDS_R_NEUTRAL]};
   assign thr_pos = (dev > 12'sh1FF) ? 11'sh3FF :
                    (dev < -12'sh1FF) ? -11'sh3FF : {dev[9:0], 1'b0};
   assign thr_mag = f_abs(thr_pos);

   // Pot sets top speed between lowest and maximum; an open pot reads as zero
   assign top_fwd = f_top(cfg_q[`SDDS_R_LOW_FWD], max_fwd, pot_adc,
                          ctrl[`SDDS_C_POT_EN]);
   assign top_rev = f_top(cfg_q[`SDDS_R_LOW_REV], cfg_q[`SDDS_R_MAX_REV], pot_adc,
                          ctrl[`SDDS_C_POT_EN]);

   // Demand scaled rather than clipped; a throttle fault and a broken wiper demand neutral
   assign target = (throttle_fault_q || wiper_broken) ? 11'sh000 :
                   thr_pos[10] ? -$signed({1'b0, f_scale(thr_mag, top_rev)}) :
                   $signed({1'b0, f_scale(thr_mag, top_fwd)});

   // Slam when the throttle opposes travel by at least the threshold
   assign opposite = (ramp_cur != 11'sh000) && (thr_pos != 11'sh000) &&
                     (ramp_cur[10] != thr_pos[10]);
   assign slam_d = ctrl[`SDDS_C_SLAM_EN] && !throttle_fault_q && !wiper_broken &&
                   ((slam_q && opposite) ||
                    (opposite && thr_mag >= f_scale(`SDDS_FS, cfg_q[`SDDS_R_SLAM_THR])));

   // Rate choice: growing speed uses acceleration, else deceleration or slam
   assign accel = (f_abs(target) > f_abs(ramp_cur)) &&
                  (ramp_cur == 11'sh000 || ramp_cur[10] == target[10]);
   assign rate_sel = slam_q ? cfg_q[`SDDS_R_SLAM_RATE] :
                     accel ? acc_pct : dec_pct;
   assign rate_lim = (rate_sel > `SDDS_PCT_MAX) ? `SDDS_PCT_MAX : rate_sel;
   assign rate_pct = rate_lim[6:0];

   // Ramp is cleared under a throttle fault so a cleared fault drives from the throttle at once
   sdds_ramp #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_ramp (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .clr(throttle_fault_q),
      .target(target),
      .rate_pct(rate_pct),
      .cur_q(ramp_cur)
   );

   // Millisecond tick for the wiper filter
   assign ms_tick = (ms_cnt_q == CPM - 32'h00000001);
   assign stopped = (ramp_cur == 11'sh000);
   assign wip_need_ms = WIPER_STEP_MS * ({12'h000, cfg_q[`SDDS_R_WIPER_ACC][3:0]} + 16'h0001);

   // Wiper break is checked only at standstill with the test enabled
   always @(posedge clk) begin
      if (rst) begin
         ms_cnt_q <= 32'h00000000;
         wip_ms_q <= 16'h0000;
      end else if (ce) begin
         ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
         if (!(wiper_broken && stopped && ctrl[`SDDS_C_WIPER_EN])) begin
            wip_ms_q <= 16'h0000;
         end else if (ms_tick && wip_ms_q < wip_need_ms) begin
            wip_ms_q <= wip_ms_q + 16'h0001;
         end
      end
   end

   // Status outputs, all registered; a detection beats a same-cycle clear
   always @(posedge clk) begin
      if (rst) begin
         throttle_fault_q <= 1'b0;
         wiper_fault_q <= 1'b0;
         slam_q <= 1'b0;
         slam_active_q <= 1'b0;
         profile2_q <= 1'b0;
         drive_inhibit_q <= 1'b0;
         speed_demand_q <= 11'sh000;
      end else if (ce) begin
         throttle_fault_q <= thr_fault_d;
         if (wip_ms_q >= wip_need_ms && wip_ms_q != 16'h0000) begin
            wiper_fault_q <= 1'b1;
         end else if (w1c_wiper) begin
            wiper_fault_q <= 1'b0;
         end
         slam_q <= slam_d;
         slam_active_q <= slam_d;
         profile2_q <= ctrl[`SDDS_C_PROF_PIN] && prof_q;
         drive_inhibit_q <= thr_fault_d;
         speed_demand_q <= thr_fault_d ? 11'sh000 : ramp_cur;
      end
   end

endmodule // sdds_shaper

`default_nettype wire

// [test/sdds_checker.sv]
`default_nettype none
module sdds_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] reg_addr,
   input wire logic [9:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic profile_pin,
   input wire logic wiper_open_pin,
   input wire logic signed [10:0] speed_demand_q,
   input wire logic drive_inhibit_q,
   input wire logic throttle_fault_q,
   input wire logic wiper_fault_q,
   input wire logic slam_active_q
   ,input wire logic profile2_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Steps of a multi-cycle behaviour
   sequence s_fault_held;
      throttle_fault_q [*2];
   endsequence
   sequence s_pin_low;
      !profile_pin [*6];
   endsequence
   // A fault may drop the demand to zero at once, otherwise one count a cycle
   property p_ramp;
      speed_demand_q == 11'sh000 ||
         (speed_demand_q - $past(speed_demand_q)) inside {-1, 0, 1};
   endproperty
   property p_sticky;
      wiper_fault_q && !(reg_wr && reg_addr == 5'h13 && reg_wdata[1]) |=> wiper_fault_q;
   endproperty
   chk_inhibit_fault: assert property (drive_inhibit_q == throttle_fault_q &&
      (!drive_inhibit_q || speed_demand_q == 11'sh000))
      else $error("drive inhibit differs from throttle fault");
   chk_fault_zero: assert property (s_fault_held |-> speed_demand_q == 11'sh000)
      else $error("demand not zero during fault");
   chk_ramp_step: assert property (p_ramp)
      else $error("demand jumped");
   chk_wiper_sticky: assert property (p_sticky)
      else $error("wiper flag dropped");
   chk_wiper_stopped: assert property ($rose(wiper_fault_q) |->
      speed_demand_q == 11'sh000 && $past(speed_demand_q) == 11'sh000)
      else $error("wiper flag while moving");
   chk_wiper_pin: assert property ($rose(wiper_fault_q) |-> $past(wiper_open_pin, 4))
      else $error("wiper flag without open pin");
   chk_slam_moving: assert property (slam_active_q |-> speed_demand_q != 11'sh000)
      else $error("slam while stopped");
   chk_profile_off: assert property (s_pin_low |-> !profile2_q)
      else $error("profile two without pin");
endmodule // sdds_checker
`default_nettype wire

// [test/sdds_pots.sv]
`default_nettype none
module sdds_pots (
   input wire logic clk,
   input wire logic [9:0] thr_set,
   input wire logic [9:0] pot_set,
   input wire logic pot_con,
   input wire logic wbreak,
   output logic [9:0] throttle_adc,
   output logic [9:0] pot_adc,
   output logic wiper_open_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Known levels before the first conversion
   initial begin
      throttle_adc = 10'h200;
      pot_adc = 10'h000;
      wiper_open_pin = 1'b0;
   end
   // Codes follow the knobs one clock late; an open wig-wag wiper floats to mid rail
   always @(posedge clk) begin
      throttle_adc <= wbreak ? 10'h200 : thr_set;
      pot_adc <= pot_con ? pot_set : 10'h000;
      wiper_open_pin <= wbreak;
   end
endmodule // sdds_pots
`default_nettype wire

// [test/testbench.sv]
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, profile_pin = 0;
   logic [4:0] reg_addr = 0;
   logic [9:0] reg_wdata = 0, thr_set = 10'h200, pot_set = 10'h3FF;
   logic pot_con = 1, wbreak = 0;
   wire logic [9:0] reg_rdata_q, throttle_adc, pot_adc;
   wire logic signed [10:0] speed_demand_q;
   wire logic wiper_open_pin, drive_inhibit_q, throttle_fault_q;
   wire logic wiper_fault_q, slam_active_q, profile2_q;
   int err_total = 0, tests_run = 0, n, e, v;
   logic [9:0] dflt [19] = '{10'h042, 10'h000, 10'h064, 10'h000, 10'h014, 10'h00A,
      10'h028, 10'h064, 10'h064, 10'h064, 10'h03C, 10'h028, 10'h03C, 10'h03C,
      10'h028, 10'h03C, 10'h021, 10'h3E2, 10'h200};
   // Small ms tick keeps ramps and filters short
   sdds_shaper #(.CYC_PER_MS(10)) u_sdds_shaper (.clk, .rst, .ce, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata_q, .throttle_adc, .pot_adc, .profile_pin,
      .wiper_open_pin, .speed_demand_q, .drive_inhibit_q, .throttle_fault_q,
      .wiper_fault_q, .slam_active_q, .profile2_q);
   sdds_pots u_sdds_pots (.clk, .thr_set, .pot_set, .pot_con, .wbreak, .throttle_adc,
      .pot_adc, .wiper_open_pin);
   initial forever #20 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic close_out;
      if (err_total == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic do_rst;
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [9:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [9:0] x);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata_q, x);
   endtask
   task automatic thr(input logic [9:0] t);
      @(posedge clk);
      thr_set <= t;
   endtask
   // Waits a bounded time for the demand, counting cycles in n
   task automatic settle(input int x);
      n = 0;
      while (speed_demand_q !== x && n < 12000) begin
         @(posedge clk);
         n++;
      end
      chk(speed_demand_q, x);
   endtask
   function automatic int tgt(int t, int pot, int mx, int lo, bit pen);
      int p, top;
      p = 2 * (t - 512);
      if (p > 1023) p = 1023;
      top = pen ? lo + ((mx - lo) * pot) / 1023 : mx;
      return (p * top * 1311) >>> 17;
   endfunction
   function automatic logic [31:0] near(int got, int exp);
      return 32'(got > exp - exp / 10 - 4 && got < exp + exp / 10 + 4);
   endfunction
   // Hang guard: far beyond the longest expected run
   initial begin
      #(40 * 100000);
      err_total++;
      close_out();
   end
   initial begin
      v = $urandom(51);
      do_rst();
      for (int i = 0; i < 19; i++) rd(i[4:0], dflt[i]);
      rd(5'h1F, 10'h000);
      e = 60;
      repeat (6) begin
         v = $urandom % 128;
         wr(5'h0A, v[9:0]);
         if (v >= 20 && v <= 100) e = v;
         rd(5'h0A, e[9:0]);
      end
      wr(5'h07, 10'h050);
      wr(5'h0A, 10'h051);
      rd(5'h0A, e[9:0]);
      wr(5'h08, 10'h032);
      wr(5'h0B, 10'h033);
      rd(5'h0B, 10'h028);
      wr(5'h03, 10'h010);
      rd(5'h03, 10'h000);
      do_rst();
      wr(5'h0B, 10'h064);
      wr(5'h0C, 10'h064);
      repeat (4) begin
         v = 512 + $urandom % 512;
         e = $urandom % 1024;
         @(posedge clk);
         thr_set <= v[9:0];
         pot_set <= e[9:0];
         settle(tgt(v, e, 60, 20, 1));
      end
      thr(10'h3FF);
      pot_con <= 1'b0;
      settle(tgt(1023, 0, 60, 20, 1));
      wr(5'h00, 10'h040);
      settle(tgt(1023, 0, 60, 20, 0));
      pot_con <= 1'b1;
      pot_set <= 10'h3FF;
      wr(5'h00, 10'h042);
      thr(10'h200);
      settle(0);
      // Full scale takes (10000 - 96 * pct) ms; measure 100 counts each way
      for (int p = 100; p >= 50; p -= 50) begin
         wr(5'h0B, p[9:0]);
         wr(5'h0C, p[9:0]);
         e = 100 * (10000 - 96 * p) * 10 / 1023;
         thr(10'h3FF);
         settle(100);
         chk(near(n, e), 1);
         thr(10'h200);
         settle(0);
         chk(near(n, e), 1);
      end
      thr(10'h3FF);
      wr(5'h11, 10'h399);
      repeat (4) @(posedge clk);
      chk(throttle_fault_q, 0);
      wr(5'h11, 10'h398);
      repeat (4) @(posedge clk);
      chk(throttle_fault_q, 1);
      wr(5'h11, 10'h3E2);
      repeat (4) @(posedge clk);
      chk(throttle_fault_q, 1);
      chk(speed_demand_q, 0);
      do_rst();
      wr(5'h00, 10'h043);
      wr(5'h0B, 10'h064);
      wr(5'h11, 10'h398);
      wr(5'h11, 10'h3E2);
      repeat (4) @(posedge clk);
      chk(throttle_fault_q, 0);
      settle(tgt(1023, 1023, 60, 20, 1));
      wr(5'h01, 10'h064);
      wr(5'h0C, 10'h000);
      thr(10'h000);
      repeat (4) @(posedge clk);
      chk(slam_active_q, 0);
      thr(10'h12C);
      wr(5'h00, 10'h047);
      repeat (4) @(posedge clk);
      chk(slam_active_q, 0);
      thr(10'h000);
      repeat (4) @(posedge clk);
      chk(slam_active_q, 1);
      // Clock enable low must freeze the braking ramp
      ce <= 1'b0;
      @(posedge clk);
      v = speed_demand_q;
      repeat (50) @(posedge clk);
      chk(speed_demand_q, v);
      ce <= 1'b1;
      settle(0);
      chk(32'(n < 2600), 1);
      do_rst();
      wr(5'h00, 10'h05A);
      wr(5'h03, 10'h001);
      wr(5'h0C, 10'h064);
      wr(5'h0B, 10'h064);
      thr(10'h3FF);
      settle(tgt(1023, 1023, 60, 20, 1));
      wbreak <= 1'b1;
      settle(0);
      chk(wiper_fault_q, 0);
      n = 0;
      while (wiper_fault_q !== 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n >= 385 && n <= 420), 1);
      wbreak <= 1'b0;
      repeat (8) @(posedge clk);
      wr(5'h13, 10'h002);
      repeat (2) @(posedge clk);
      chk(wiper_fault_q, 0);
      profile_pin <= 1'b1;
      repeat (8) @(posedge clk);
      chk(profile2_q, 0);
      wr(5'h00, 10'h062);
      wr(5'h0D, 10'h01E);
      wr(5'h0E, 10'h064);
      wr(5'h0F, 10'h064);
      repeat (8) @(posedge clk);
      chk(profile2_q, 1);
      settle(tgt(1023, 1023, 30, 20, 1));
      close_out();
   end
endmodule // testbench
bind sdds_shaper sdds_checker u_sdds_checker (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
   .profile_pin, .wiper_open_pin, .speed_demand_q, .drive_inhibit_q, .throttle_fault_q,
   .wiper_fault_q, .slam_active_q, .profile2_q);
`default_nettype wire
